// file: sbie_map.svh
`ifndef SBIE_MAP_SVH
`define SBIE_MAP_SVH
// **************************************************************
// widths, field positions and reset values
// **************************************************************
`define SBIE_DATA_W     8
`define SBIE_PC_W       13
`define SBIE_LIT_W      11
`define SBIE_FADDR_W    7
`define SBIE_LATCH_HI   4
`define SBIE_LATCH_LO   3
`define SBIE_BYTE_HI    7
`define SBIE_DEST_WORK  1'b0
`define SBIE_DEST_FILE  1'b1
`define SBIE_W_RST      8'h00
`define SBIE_PC_RST     13'h0000
`define SBIE_ONE        8'h01
`define SBIE_PC_STEP    13'h0001
`endif

// file: sbie_pkg.sv
`default_nettype none
// **************************************************************
// shared types
// **************************************************************
package sbie_pkg;
  // operation selector handed over by the fetch stage
  typedef enum logic [2:0] {
    SBIE_NO_OPERATION            = 3'h0,
    SBIE_DECREMENT_SKIP_IF_ZERO  = 3'h1,
    SBIE_INCREMENT_SKIP_IF_ZERO  = 3'h2,
    SBIE_JUMP_UNCONDITIONAL      = 3'h3,
    SBIE_OR_LITERAL_INTO_WORKING = 3'h4,
    SBIE_INCREMENT_FILE          = 3'h5,
    SBIE_OR_WORKING_WITH_FILE    = 3'h6
  } sbie_op_t;

  // one decoded instruction word
  typedef struct packed {
    sbie_op_t    op;    // operation
    logic        dest;  // 0 working register, 1 file register
    logic [6:0]  faddr; // file register address, 0..127
    logic [10:0] lit;   // literal, 8 bits used by or-literal
  } sbie_instr_t;

  // registered write toward the register file
  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] data;
  } sbie_fwrite_t;
endpackage
`default_nettype wire

// file: sbie_exec.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbie_map.svh"
module sbie_exec
(
  input  wire logic                         core_clk,
  input  wire logic                         nrst,
  input  wire logic                         instr_valid,
  input  wire sbie_pkg::sbie_instr_t        instr,
  input  wire logic [`SBIE_DATA_W-1:0]      latch_bits,
  input  wire logic [`SBIE_DATA_W-1:0]      file_rdata,
  output logic [`SBIE_FADDR_W-1:0]          file_raddr,
  output sbie_pkg::sbie_fwrite_t            file_wr,
  output logic [`SBIE_DATA_W-1:0]           work_q,
  output logic                              zero_q,
  output logic [`SBIE_PC_W-1:0]             pc_q,
  output logic                              slot_nop_q
);

  // **************************************************************
  // helpers
  // **************************************************************

  // zero detect over one byte, used by every flag update
  function automatic logic is_zero(input logic [`SBIE_DATA_W-1:0] v);
    is_zero = (v == `SBIE_W_RST);
  endfunction

  // **************************************************************
  // decode and datapath
  // **************************************************************
  logic                       discard_q;  // next accepted slot is a nop
  sbie_pkg::sbie_op_t         op;         // effective operation
  logic [`SBIE_DATA_W-1:0]    result;     // alu result
  logic                       zero_res;   // result is all zeros
  logic                       skip_op;    // op is a skip-on-zero
  logic                       flag_op;    // op updates the zero flag
  logic                       to_work;    // result lands in working reg

  // read address follows the presented word directly
  assign file_raddr = instr.faddr;

  // a discarded slot runs as a no-operation whatever was fetched
  always_comb
  begin
    if (instr_valid && !discard_q)
      op = instr.op;
    else
      op = sbie_pkg::SBIE_NO_OPERATION;
  end

  // result selection per operation
  always_comb
  begin
    result  = work_q;
    flag_op = 1'b0;
    skip_op = 1'b0;
    to_work = 1'b0;
    unique case (op)
      sbie_pkg::SBIE_DECREMENT_SKIP_IF_ZERO:
      begin
        result  = file_rdata - `SBIE_ONE;
        skip_op = 1'b1;
        to_work = (instr.dest == `SBIE_DEST_WORK);
      end
      sbie_pkg::SBIE_INCREMENT_SKIP_IF_ZERO:
      begin
        result  = file_rdata + `SBIE_ONE;
        skip_op = 1'b1;
        to_work = (instr.dest == `SBIE_DEST_WORK);
      end
      sbie_pkg::SBIE_OR_LITERAL_INTO_WORKING:
      begin
        result  = work_q | instr.lit[`SBIE_BYTE_HI:0];
        flag_op = 1'b1;
        to_work = 1'b1;
      end
      sbie_pkg::SBIE_INCREMENT_FILE:
      begin
        result  = file_rdata + `SBIE_ONE;
        flag_op = 1'b1;
        to_work = (instr.dest == `SBIE_DEST_WORK);
      end
      sbie_pkg::SBIE_OR_WORKING_WITH_FILE:
      begin
        result  = work_q | file_rdata;
        flag_op = 1'b1;
        to_work = (instr.dest == `SBIE_DEST_WORK);
      end
      // jump and no-operation leave the datapath idle
      sbie_pkg::SBIE_JUMP_UNCONDITIONAL,
      sbie_pkg::SBIE_NO_OPERATION:
      begin
        result = work_q;
      end
      // code 7 is illegal and is run as a no-operation
      default:
      begin
        result = work_q;
      end
    endcase
  end

  assign zero_res = is_zero(result);

  // **************************************************************
  // working register
  // **************************************************************

  // only working-destination results land here
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      work_q <= `SBIE_W_RST;
    else if (to_work)
      work_q <= result;
  end

  // **************************************************************
  // zero flag
  // **************************************************************

  // skip ops are left out on purpose, flag holds across them
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      zero_q <= 1'b0;
    else if (flag_op && !skip_op)
      zero_q <= zero_res;
  end

  // **************************************************************
  // file register write port
  // **************************************************************

  // registered write, one cycle after the instruction slot
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      file_wr.we   <= 1'b0;
      file_wr.addr <= '0;
      file_wr.data <= `SBIE_W_RST;
    end
    else
    begin
      file_wr.we   <= (skip_op || flag_op) && !to_work;
      file_wr.addr <= instr.faddr;
      file_wr.data <= result;
    end
  end

  // **************************************************************
  // skip and flush
  // **************************************************************

  // a zero skip result or a jump kills the already fetched word;
  // the killed slot is the second instruction cycle
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      discard_q <= 1'b0;
    else if (skip_op)
      discard_q <= zero_res;
    else if (op == sbie_pkg::SBIE_JUMP_UNCONDITIONAL)
      discard_q <= 1'b1;
    else if (instr_valid)
      discard_q <= 1'b0;
  end

  // pulse marking a discarded slot spent as a no-operation; a fetched no-operation or code 7 gives none
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      slot_nop_q <= 1'b0;
    else
      slot_nop_q <= instr_valid && discard_q;
  end

  // **************************************************************
  // program counter
  // **************************************************************

  // steps once per accepted slot; jump forms a 13-bit target
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      pc_q <= `SBIE_PC_RST;
    else if (op == sbie_pkg::SBIE_JUMP_UNCONDITIONAL)
      pc_q <= {latch_bits[`SBIE_LATCH_HI:`SBIE_LATCH_LO], instr.lit};
    else if (instr_valid)
      pc_q <= pc_q + `SBIE_PC_STEP;
  end

  // **************************************************************
  // checks
  // **************************************************************
  logic live; // a real instruction executes this slot
  assign live = instr_valid && !discard_q;

  sequence s_skip_zero;
    live && skip_op && zero_res;
  endsequence

  sequence s_slot_killed;
    discard_q ##0 (instr_valid [*1]) ##1 slot_nop_q && !file_wr.we;
  endsequence

  a_dec_route: assert property (@(posedge core_clk) disable iff (!nrst)
    live && op == sbie_pkg::SBIE_DECREMENT_SKIP_IF_ZERO && instr.dest == `SBIE_DEST_WORK
    |=> work_q == $past(file_rdata) - `SBIE_ONE && !file_wr.we)
    else $error("decrement result not in working register");
  a_skip_kills: assert property (@(posedge core_clk) disable iff (!nrst)
    s_skip_zero |=> discard_q)
    else $error("zero skip result did not arm discard");
  a_skip_slot_nop: assert property (@(posedge core_clk) disable iff (!nrst)
    s_slot_killed or (discard_q && !instr_valid) or !discard_q)
    else $error("discarded slot not run as no-operation");
  a_noskip_flows: assert property (@(posedge core_clk) disable iff (!nrst)
    live && skip_op && !zero_res |=> !discard_q)
    else $error("nonzero skip result discarded next word");
  a_inc_skip_file: assert property (@(posedge core_clk) disable iff (!nrst)
    live && op == sbie_pkg::SBIE_INCREMENT_SKIP_IF_ZERO && instr.dest == `SBIE_DEST_FILE
    |=> file_wr.we && file_wr.data == $past(file_rdata) + `SBIE_ONE && discard_q == (file_wr.data == `SBIE_W_RST))
    else $error("increment-skip file write or skip wrong");
  a_skip_keeps_z: assert property (@(posedge core_clk) disable iff (!nrst)
    live && skip_op |=> $stable(zero_q))
    else $error("skip instruction changed zero flag");
  a_jump_target: assert property (@(posedge core_clk) disable iff (!nrst)
    live && op == sbie_pkg::SBIE_JUMP_UNCONDITIONAL
    |=> pc_q == {$past(latch_bits[`SBIE_LATCH_HI:`SBIE_LATCH_LO]), $past(instr.lit)} && $stable(zero_q))
    else $error("jump target wrong");
  a_jump_two_cyc: assert property (@(posedge core_clk) disable iff (!nrst)
    live && op == sbie_pkg::SBIE_JUMP_UNCONDITIONAL |=> discard_q)
    else $error("jump did not take a second cycle");
  a_or_literal: assert property (@(posedge core_clk) disable iff (!nrst)
    live && op == sbie_pkg::SBIE_OR_LITERAL_INTO_WORKING
    |=> work_q == ($past(work_q) | $past(instr.lit[`SBIE_BYTE_HI:0])) && zero_q == (work_q == `SBIE_W_RST))
    else $error("or-literal result or zero flag wrong");
  a_increment_file_route: assert property (@(posedge core_clk) disable iff (!nrst)
    live && op == sbie_pkg::SBIE_INCREMENT_FILE && instr.dest == `SBIE_DEST_FILE
    |=> file_wr.we && file_wr.data == $past(file_rdata) + `SBIE_ONE && $stable(work_q))
    else $error("increment file write wrong");
  a_orfile_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    live && op == sbie_pkg::SBIE_OR_WORKING_WITH_FILE
    |=> zero_q == (($past(work_q) | $past(file_rdata)) == `SBIE_W_RST))
    else $error("or-file zero flag wrong");
  a_zero_exact: assert property (@(posedge core_clk) disable iff (!nrst)
    live && flag_op && !to_work |=> zero_q == (file_wr.data == `SBIE_W_RST))
    else $error("zero flag disagrees with result");

endmodule
`default_nettype wire

// file: sbie_tb.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ************************************************************
  // stimulus, observed outputs and expected state
  // ************************************************************
  logic                   core_clk;    // 125 MHz core clock
  logic                   nrst;        // async reset, active low
  logic                   instr_valid; // slot holds an instruction
  sbie_pkg::sbie_instr_t  instr;       // decoded word
  logic [7:0]             latch_bits;  // program counter high latch
  logic [7:0]             file_rdata;  // register file read data
  logic [6:0]             file_raddr;  // register file read address
  sbie_pkg::sbie_fwrite_t file_wr;     // register file write
  logic [7:0]             work_q;      // working register
  logic                   zero_q;      // zero flag
  logic [12:0]            pc_q;        // program counter
  logic                   slot_nop_q;  // discarded slot marker
  logic [7:0]             mem [128];   // register file seen by the design
  logic [7:0]             e_mem [128]; // expected register file
  logic [7:0]             e_w;         // expected working register
  logic                   e_z;         // expected zero flag
  logic [12:0]            e_pc;        // expected program counter
  logic                   e_skip;      // discard pending in the model
  logic                   e_nop;       // expected discard marker
  logic                   e_we;        // expected write strobe
  logic [6:0]             e_addr;      // expected write address
  logic [7:0]             e_data;      // expected write data
  integer                 error_cnt;   // mismatches
  integer                 n_compared;  // comparisons
  integer                 seed;        // fixed seed
  integer                 k;           // loop index
  logic [31:0]            r;           // random word

  sbie_exec uut
  (
    .core_clk    (core_clk),
    .nrst        (nrst),
    .instr_valid (instr_valid),
    .instr       (instr),
    .latch_bits  (latch_bits),
    .file_rdata  (file_rdata),
    .file_raddr  (file_raddr),
    .file_wr     (file_wr),
    .work_q      (work_q),
    .zero_q      (zero_q),
    .pc_q        (pc_q),
    .slot_nop_q  (slot_nop_q)
  );

  // free-running clock
  always #4 core_clk = ~core_clk;

  // ************************************************************
  // register file: bypass so a write in flight is seen at once
  // ************************************************************
  assign file_rdata = (file_wr.we && file_wr.addr == file_raddr) ? file_wr.data : mem[file_raddr];
  // writes land one cycle after the slot, as the design registers them
  always @(posedge core_clk)
  begin
    if (file_wr.we)
    begin
      mem[file_wr.addr] <= file_wr.data;
    end
  end

  // ************************************************************
  // reference model of one slot
  // ************************************************************
  function automatic void route(input sbie_pkg::sbie_instr_t i, input logic [7:0] res);
    if (i.dest)
    begin
      e_we = 1'b1;
      e_addr = i.faddr;
      e_data = res;
      e_mem[i.faddr] = res;
    end
    else
    begin
      e_w = res;
    end
  endfunction

  function automatic void predict(input sbie_pkg::sbie_instr_t i, input logic [7:0] l);
    logic [7:0] f;
    f = e_mem[i.faddr];
    e_we = 1'b0;
    e_nop = 1'b0;
    e_pc = e_pc + 13'h0001;
    // a pending discard swallows this slot whatever it holds
    if (e_skip)
    begin
      e_skip = 1'b0;
      e_nop = 1'b1;
      return;
    end
    case (i.op)
      sbie_pkg::SBIE_DECREMENT_SKIP_IF_ZERO:
      begin
        route(i, f - 8'h01);
        e_skip = (f == 8'h01);
      end
      sbie_pkg::SBIE_INCREMENT_SKIP_IF_ZERO:
      begin
        route(i, f + 8'h01);
        e_skip = (f == 8'hFF);
      end
      sbie_pkg::SBIE_INCREMENT_FILE:
      begin
        route(i, f + 8'h01);
        e_z = (f == 8'hFF);
      end
      sbie_pkg::SBIE_OR_WORKING_WITH_FILE:
      begin
        e_z = ((e_w | f) == 8'h00);
        route(i, e_w | f);
      end
      sbie_pkg::SBIE_OR_LITERAL_INTO_WORKING:
      begin
        e_w = e_w | i.lit[7:0];
        e_z = (e_w == 8'h00);
      end
      sbie_pkg::SBIE_JUMP_UNCONDITIONAL:
      begin
        e_pc = {l[4:3], i.lit};
        e_skip = 1'b1;
      end
      default:
      begin
      end
    endcase
  endfunction

  // ************************************************************
  // drivers and comparison
  // ************************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // drive at the falling edge, compare one cycle later
  // the word is exactly as wide as the decoded instruction struct
  task automatic run_slot(input logic v, input logic [21:0] w, input logic [7:0] l);
    instr_valid = v;
    instr = sbie_pkg::sbie_instr_t'(w);
    latch_bits = l;
    e_we = 1'b0;
    e_nop = 1'b0;
    if (v)
    begin
      predict(instr, l);
    end
    @(negedge core_clk);
    chk(16'(work_q), 16'(e_w));
    chk(16'(zero_q), 16'(e_z));
    chk(16'(pc_q), 16'(e_pc));
    chk(16'(slot_nop_q), 16'(e_nop));
    chk(16'(file_raddr), 16'(instr.faddr));
    chk(16'(file_wr.we), 16'(e_we));
    if (e_we)
    begin
      chk({1'b0, file_wr.addr, file_wr.data}, {1'b0, e_addr, e_data});
    end
  endtask

  // reset also clears any discard the model holds
  task automatic do_reset();
    instr_valid = 1'b0;
    // let a registered write still in flight land before reset clears it
    if (nrst)
    begin
      @(negedge core_clk);
    end
    nrst = 1'b0;
    repeat (10) @(negedge core_clk);
    {e_w, e_z, e_pc, e_skip} = '0;
    nrst = 1'b1;
  endtask

  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    {core_clk, nrst, instr_valid, instr, latch_bits, error_cnt, n_compared} = '0;
    seed = 32'hBEEC;
    for (k = 0; k < 128; k++)
    begin
      r = $random(seed);
      mem[k] = r[7:0];
    end
    mem[5] = 8'h01;
    mem[6] = 8'hFF;
    mem[7] = 8'h03;
    e_mem = mem;
    do_reset();
    // op, dest, faddr, lit
    run_slot(1'b1, {3'h4, 1'b0, 7'h00, 11'h000}, 8'h00);
    run_slot(1'b1, {3'h1, 1'b1, 7'h05, 11'h000}, 8'h00);
    run_slot(1'b1, {3'h4, 1'b0, 7'h00, 11'h0FF}, 8'h00);
    run_slot(1'b1, {3'h2, 1'b0, 7'h06, 11'h000}, 8'h00);
    run_slot(1'b1, {3'h5, 1'b1, 7'h06, 11'h000}, 8'h00);
    run_slot(1'b1, {3'h4, 1'b0, 7'h00, 11'h05A}, 8'h00);
    run_slot(1'b1, {3'h3, 1'b0, 7'h00, 11'h7FF}, 8'h18);
    run_slot(1'b1, {3'h5, 1'b1, 7'h07, 11'h000}, 8'h18);
    run_slot(1'b1, {3'h1, 1'b0, 7'h07, 11'h000}, 8'h00);
    run_slot(1'b1, {3'h6, 1'b1, 7'h07, 11'h000}, 8'h00);
    run_slot(1'b1, {3'h5, 1'b0, 7'h05, 11'h000}, 8'h00);
    run_slot(1'b0, {3'h2, 1'b1, 7'h05, 11'h000}, 8'h00);
    $display("test corner cases done");
    for (k = 0; k < 600; k++)
    begin
      r = $random(seed);
      run_slot(r[31:30] != 2'b00, r[21:0], r[31:24]);
      if (k == 300)
      begin
        do_reset();
      end
    end
    $display("test random slots done");
    give_verdict();
  end
endmodule
`default_nettype wire
